// file: rtl/option_byte_config_decoder.sv
// option byte store, programming-mode register port and configuration decoder
// assumes core logic on core_clk, programming-mode pin asynchronous
`timescale 1ns/1ps
`include "option_cfg.svh"
module option_byte_config_decoder
    import option_pkg::*;
#(
    parameter logic       ROM_PART = 1'b0,
    parameter logic [7:0] ROM_OPT0 = `SHIP_OPT0,
    parameter logic [7:0] ROM_OPT1 = `SHIP_OPT1
) (
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               factory_load,
    input  wire logic               prog_mode_pin,
    input  wire bus_req_t           bus_req,
    output logic [7:0]              bus_rdata,
    input  wire logic               halt_entry,
    input  wire logic               sw_watchdog_enable,
    input  wire logic               mem_erase_done,
    output logic                    mem_erase_req,
    output logic                    halt_reset_req,
    output logic                    watchdog_hw_always_on,
    output logic                    low_voltage_detector_on,
    output logic                    auxiliary_voltage_detector_on,
    output voltage_detect_threshold_t voltage_detect_threshold,
    output logic [1:0]              sector_zero_size,
    output logic                    readout_block,
    output logic                    flash_write_block,
    output logic                    program_memory_write_protected,
    output logic                    port_c_irq_mapping,
    output clock_source_type_t      clock_source_type,
    output logic                    clock_source_reserved,
    output oscillator_freq_range_t  oscillator_freq_range,
    output logic                    pll_x2_enable,
    output logic                    pll_misuse
);

    typedef struct packed {
        ctl_state_t st;
        logic       refused;
        logic [7:0] stage0;
        logic [7:0] stage1;
        logic [7:0] rdata;
        logic       halt_rst;
        logic       erase_req;
        logic       program_pulse;
        logic       erase_pulse;
        cfg_t       cfg;
    } core_state_t;

    core_state_t state_ff;
    core_state_t nxt_state;
    logic        prog_mode;
    logic [7:0]  opt0;
    logic [7:0]  opt1;
    logic        wdg_active;
    logic        cmd_program;
    logic        cmd_erase;

    pin_sync #(
        .RESET_LEVEL (1'b0)
    ) u_prog_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin      (prog_mode_pin),
        .level    (prog_mode)
    );

    option_cell #(
        .SHIP_VALUE (`SHIP_OPT0),
        .ROM_VALUE  (ROM_OPT0),
        .ROM_PART   (ROM_PART)
    ) u_opt0 (
        .core_clk     (core_clk),
        .factory_load (factory_load),
        .program_en   (state_ff.program_pulse),
        .erase_en     (state_ff.erase_pulse),
        .wdata        (state_ff.stage0),
        .value        (opt0)
    );

    option_cell #(
        .SHIP_VALUE (`SHIP_OPT1),
        .ROM_VALUE  (ROM_OPT1),
        .ROM_PART   (ROM_PART)
    ) u_opt1 (
        .core_clk     (core_clk),
        .factory_load (factory_load),
        .program_en   (state_ff.program_pulse),
        .erase_en     (state_ff.erase_pulse),
        .wdata        (state_ff.stage1),
        .value        (opt1)
    );

    // raw option bytes to decoded configuration
    function automatic cfg_t decode(input logic [7:0] b0, input logic [7:0] b1);
        cfg_t c;
        c = '0;
        c.halt_entry_watchdog_reset = b0[`OPT0_HALT_WDG_BIT];
        c.watchdog_hw_always_on = ~b0[`OPT0_WDG_TYPE_BIT];
        unique case (b0[`OPT0_VD_HI:`OPT0_VD_LO])
            2'h3: c.voltage_detect_threshold = vd_off;
            2'h2: c.voltage_detect_threshold = vd_lowest;
            2'h1: c.voltage_detect_threshold = vd_medium;
            2'h0: c.voltage_detect_threshold = vd_highest;
        endcase
        c.low_voltage_detector_on = (b0[`OPT0_VD_HI:`OPT0_VD_LO] != 2'h3);
        // sector size, 4k on rom only
        c.sector_zero_size = b0[`OPT0_SEC_HI:`OPT0_SEC_LO];
        if (!ROM_PART && c.sector_zero_size == 2'h3) begin
            c.sector_zero_size = 2'h2;
        end
        c.read_protection_enable = b0[`OPT0_RD_PROT_BIT];
        c.write_protection_enable = b0[`OPT0_WR_PROT_BIT];
        c.port_c_irq_mapping = b1[`OPT1_IRQ_MAP_BIT];
        unique case (b1[`OPT1_SRC_HI:`OPT1_SRC_LO])
            2'h0: c.clock_source_type = src_resonator;
            2'h1: c.clock_source_type = src_reserved;
            2'h2: c.clock_source_type = src_internal_rc;
            2'h3: c.clock_source_type = src_external;
        endcase
        c.clock_source_reserved = (b1[`OPT1_SRC_HI:`OPT1_SRC_LO] == 2'h1);
        unique casez (b1[`OPT1_RNG_HI:`OPT1_RNG_LO])
            3'b1??: c.oscillator_freq_range = very_low_power_range;
            3'b000: c.oscillator_freq_range = low_power_range;
            3'b001: c.oscillator_freq_range = medium_power_range;
            3'b010: c.oscillator_freq_range = medium_speed_range;
            3'b011: c.oscillator_freq_range = high_speed_range;
        endcase
        c.pll_x2_enable = ~b1[`OPT1_PLL_OFF_BIT];
        c.pll_misuse = c.pll_x2_enable &&
                       (c.clock_source_type == src_internal_rc ||
                        c.oscillator_freq_range != medium_power_range);
        return c;
    endfunction

    assign wdg_active  = state_ff.cfg.watchdog_hw_always_on | sw_watchdog_enable;
    assign cmd_program = prog_mode && bus_req.wr && bus_req.addr == `REG_COMMAND
                         && bus_req.wdata[`CMD_PROGRAM_BIT];
    assign cmd_erase   = prog_mode && bus_req.wr && bus_req.addr == `REG_COMMAND
                         && bus_req.wdata[`CMD_ERASE_BIT] && !bus_req.wdata[`CMD_PROGRAM_BIT];

    always_comb begin
        nxt_state               = state_ff;
        nxt_state.program_pulse = 1'b0;
        nxt_state.erase_pulse   = 1'b0;
        nxt_state.rdata         = 8'h00;
        nxt_state.halt_rst = halt_entry && wdg_active && state_ff.cfg.halt_entry_watchdog_reset;

        // staging writes only in programming mode
        if (prog_mode && bus_req.wr && bus_req.addr == `REG_OPT_BYTE0) begin
            nxt_state.stage0 = bus_req.wdata;
        end
        if (prog_mode && bus_req.wr && bus_req.addr == `REG_OPT_BYTE1) begin
            nxt_state.stage1 = bus_req.wdata;
        end
        if (bus_req.wr && bus_req.addr == `REG_STATUS && bus_req.wdata[`STS_REFUSED_BIT]) begin
            nxt_state.refused = 1'b0;
        end

        unique case (state_ff.st)
            st_idle: begin
                if (cmd_program || cmd_erase) begin
                    if (ROM_PART || opt0[`OPT0_WR_PROT_BIT]) begin
                        nxt_state.refused = 1'b1;
                    end else if (cmd_program) begin
                        nxt_state.program_pulse = 1'b1;
                    end else if (opt0[`OPT0_RD_PROT_BIT]) begin
                        nxt_state.erase_req = 1'b1;
                        nxt_state.st        = st_wipe;
                    end else begin
                        nxt_state.erase_pulse = 1'b1;
                    end
                end
            end
            st_wipe: begin
                if (cmd_program || cmd_erase) begin
                    nxt_state.refused = 1'b1;
                end
                if (mem_erase_done) begin
                    nxt_state.erase_req   = 1'b0;
                    nxt_state.erase_pulse = 1'b1;
                    nxt_state.st          = st_idle;
                end
            end
        endcase

        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `REG_OPT_BYTE0: nxt_state.rdata = prog_mode ? opt0 : `READ_HIDDEN;
                `REG_OPT_BYTE1: nxt_state.rdata = prog_mode ? opt1 : `READ_HIDDEN;
                `REG_STATUS: begin
                    nxt_state.rdata[`STS_BUSY_BIT]      = (state_ff.st == st_wipe);
                    nxt_state.rdata[`STS_REFUSED_BIT]   = state_ff.refused;
                    nxt_state.rdata[`STS_PROG_MODE_BIT] = prog_mode;
                    nxt_state.rdata[`STS_ROM_BIT]       = ROM_PART;
                    nxt_state.rdata[`STS_WR_PROT_BIT]   = opt0[`OPT0_WR_PROT_BIT];
                end
                default: nxt_state.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff        <= '0;
            state_ff.st     <= st_idle;
            state_ff.stage0 <= `ERASED_BYTE;
            state_ff.stage1 <= `ERASED_BYTE;
            state_ff.cfg    <= decode(opt0, opt1);
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus_rdata                     = state_ff.rdata;
    assign mem_erase_req                 = state_ff.erase_req;
    assign halt_reset_req                = state_ff.halt_rst;
    assign watchdog_hw_always_on         = state_ff.cfg.watchdog_hw_always_on;
    assign low_voltage_detector_on       = state_ff.cfg.low_voltage_detector_on;
    assign auxiliary_voltage_detector_on = state_ff.cfg.low_voltage_detector_on;
    assign voltage_detect_threshold      = state_ff.cfg.voltage_detect_threshold;
    assign sector_zero_size              = state_ff.cfg.sector_zero_size;
    assign readout_block                 = state_ff.cfg.read_protection_enable;
    assign flash_write_block             = state_ff.cfg.read_protection_enable |
                                           state_ff.cfg.write_protection_enable;
    assign program_memory_write_protected = state_ff.cfg.write_protection_enable;
    assign port_c_irq_mapping            = state_ff.cfg.port_c_irq_mapping;
    assign clock_source_type             = state_ff.cfg.clock_source_type;
    assign clock_source_reserved         = state_ff.cfg.clock_source_reserved;
    assign oscillator_freq_range         = state_ff.cfg.oscillator_freq_range;
    assign pll_x2_enable                 = state_ff.cfg.pll_x2_enable;
    assign pll_misuse                    = state_ff.cfg.pll_misuse;

endmodule

// file: rtl/option_cfg.svh
// option byte map, command bits, register offsets and ship defaults
// assumes byte wide option storage and a 4-bit byte address register port
`ifndef OPTION_CFG_SVH
`define OPTION_CFG_SVH

// register byte offsets
`define REG_OPT_BYTE0       4'h0
`define REG_OPT_BYTE1       4'h4
`define REG_COMMAND         4'h8
`define REG_STATUS          4'hC

// command register bits
`define CMD_PROGRAM_BIT     0
`define CMD_ERASE_BIT       1

// status register bits
`define STS_BUSY_BIT        0
`define STS_REFUSED_BIT     1
`define STS_PROG_MODE_BIT   2
`define STS_ROM_BIT         3
`define STS_WR_PROT_BIT     4

// option byte 0 fields
`define OPT0_HALT_WDG_BIT   7
`define OPT0_WDG_TYPE_BIT   6
`define OPT0_VD_HI          5
`define OPT0_VD_LO          4
`define OPT0_SEC_HI         3
`define OPT0_SEC_LO         2
`define OPT0_RD_PROT_BIT    1
`define OPT0_WR_PROT_BIT    0

// option byte 1 fields
`define OPT1_IRQ_MAP_BIT    7
`define OPT1_RESERVED_BIT   6
`define OPT1_SRC_HI         5
`define OPT1_SRC_LO         4
`define OPT1_RNG_HI         3
`define OPT1_RNG_LO         1
`define OPT1_PLL_OFF_BIT    0

// values
`define ERASED_BYTE         8'hFF
`define SHIP_OPT0           8'hFC
`define SHIP_OPT1           8'hEF
`define READ_HIDDEN         8'h00

`endif

// file: rtl/option_pkg.sv
// types shared by the option byte decoder and its helpers
// assumes option_cfg.svh supplies all offsets and values
package option_pkg;

    typedef enum logic [1:0] {vd_off, vd_lowest, vd_medium, vd_highest} voltage_detect_threshold_t;

    typedef enum logic [1:0] {src_resonator, src_reserved, src_internal_rc, src_external} clock_source_type_t;

    typedef enum logic [2:0] {
        very_low_power_range,
        low_power_range,
        medium_power_range,
        medium_speed_range,
        high_speed_range
    } oscillator_freq_range_t;

    typedef enum logic {st_idle, st_wipe} ctl_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic                      halt_entry_watchdog_reset;
        logic                      watchdog_hw_always_on;
        logic                      low_voltage_detector_on;
        voltage_detect_threshold_t voltage_detect_threshold;
        logic [1:0]                sector_zero_size;
        logic                      read_protection_enable;
        logic                      write_protection_enable;
        logic                      port_c_irq_mapping;
        clock_source_type_t        clock_source_type;
        logic                      clock_source_reserved;
        oscillator_freq_range_t    oscillator_freq_range;
        logic                      pll_x2_enable;
        logic                      pll_misuse;
    } cfg_t;

    typedef struct packed {
        logic [7:0] bits;
    } cell_t;

    typedef struct packed {
        logic [2:0] stages;
        logic       level;
    } sync_t;

endpackage

// file: rtl/pin_sync.sv
// three stage synchroniser for one pin level
// assumes the pin is asynchronous to core_clk
`timescale 1ns/1ps
module pin_sync
    import option_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level
);

    sync_t state_ff;
    sync_t nxt_state;

    // level moves once stages two and three agree
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.stages = {state_ff.stages[1:0], pin};
        if (state_ff.stages[1] == state_ff.stages[2]) begin
            nxt_state.level = state_ff.stages[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= '{stages: {3{RESET_LEVEL}}, level: RESET_LEVEL};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level = state_ff.level;

endmodule

// file: rtl/option_cell.sv
// one non-volatile option byte: program writes the staged byte, erase sets all ones
// assumes factory_load is pulsed once at power-up, not by sys_rst
`timescale 1ns/1ps
`include "option_cfg.svh"
module option_cell
    import option_pkg::*;
#(
    parameter logic [7:0] SHIP_VALUE = `SHIP_OPT0,
    parameter logic [7:0] ROM_VALUE  = `ERASED_BYTE,
    parameter logic       ROM_PART   = 1'b0
) (
    input  wire logic       core_clk,
    input  wire logic       factory_load,
    input  wire logic       program_en,
    input  wire logic       erase_en,
    input  wire logic [7:0] wdata,
    output logic [7:0]      value
);

    cell_t state_ff;
    cell_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (factory_load) begin
            nxt_state.bits = SHIP_VALUE;
        end else if (erase_en) begin
            nxt_state.bits = `ERASED_BYTE;
        end else if (program_en) begin
            nxt_state.bits = wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        state_ff <= nxt_state;
    end

    assign value = ROM_PART ? ROM_VALUE : state_ff.bits;

endmodule

// file: bench/option_programmer.sv
// programming tool model: bus master, mode pin and memory wiper
// assumes one core_clk shared with the decoder, tasks called from the bench
`timescale 1ns/1ps
`include "option_cfg.svh"
module option_programmer
    import option_pkg::*;
#(
    parameter int WIPE_CYC = 8
) (
    input  wire logic       core_clk,
    input  wire logic       mem_erase_req,
    input  wire logic [7:0] bus_rdata,
    output bus_req_t        bus_req,
    output logic            prog_mode_pin,
    output logic            mem_erase_done
);
    logic [7:0] wipe_cnt;

    initial begin
        bus_req = '0;
        prog_mode_pin = 1'h0;
        mem_erase_done = 1'h0;
        wipe_cnt = 8'h00;
    end

    // wiper answers a whole-memory erase after a delay
    always @(posedge core_clk) begin
        wipe_cnt <= (mem_erase_req && !mem_erase_done) ? wipe_cnt + 8'h01 : 8'h00;
        mem_erase_done <= mem_erase_req && (wipe_cnt == 8'(WIPE_CYC));
    end

    task automatic set_mode(input logic lvl);
        @(posedge core_clk);
        prog_mode_pin <= lvl;
    endtask

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == `REG_OPT_BYTE1) d[`OPT1_RESERVED_BIT] = 1'h1;
        if (addr == `REG_OPT_BYTE1 && !d[0] && (d[5:4] == 2'h2 || d[3:1] != 3'h1)) d[0] = 1'h1;
        @(posedge core_clk);
        bus_req <= '{addr: addr, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    task automatic rd(input logic [3:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge core_clk);
        bus_req <= '0;
        @(negedge core_clk);
        data = bus_rdata;
    endtask
endmodule

// file: bench/option_byte_config_decoder_chk.sv
// port checker for the option byte decoder
// assumes bound to every decoder instance, one clock domain
`timescale 1ns/1ps
module option_chk
    import option_pkg::*;
#(
    parameter logic ROM_PART = 1'h0
) (
    input wire logic                      core_clk,
    input wire logic                      sys_rst,
    input wire bus_req_t                  bus_req,
    input wire logic [7:0]                bus_rdata,
    input wire logic                      halt_entry,
    input wire logic                      sw_watchdog_enable,
    input wire logic                      mem_erase_done,
    input wire logic                      mem_erase_req,
    input wire logic                      halt_reset_req,
    input wire logic                      watchdog_hw_always_on,
    input wire logic                      low_voltage_detector_on,
    input wire logic                      auxiliary_voltage_detector_on,
    input wire voltage_detect_threshold_t voltage_detect_threshold,
    input wire logic [1:0]                sector_zero_size,
    input wire logic                      readout_block,
    input wire logic                      flash_write_block,
    input wire logic                      program_memory_write_protected,
    input wire clock_source_type_t        clock_source_type,
    input wire logic                      clock_source_reserved,
    input wire oscillator_freq_range_t    oscillator_freq_range,
    input wire logic                      pll_x2_enable,
    input wire logic                      pll_misuse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_wipe_done;
        mem_erase_req && mem_erase_done;
    endsequence
    sequence s_req_drop;
        ##1 !mem_erase_req;
    endsequence

    AST_HALT_CAUSE: assert property (halt_reset_req |-> $past(halt_entry))
        else $error("halt reset without halt entry");
    AST_HALT_SW_OFF: assert property (halt_entry && !watchdog_hw_always_on && !sw_watchdog_enable |=> !halt_reset_req)
        else $error("halt reset with watchdog inactive");
    AST_VD: assert property (low_voltage_detector_on == (voltage_detect_threshold != vd_off)
        && auxiliary_voltage_detector_on == low_voltage_detector_on)
        else $error("detector enable disagrees with threshold");
    AST_SEC: assert property (sector_zero_size == 2'h3 |-> ROM_PART)
        else $error("4k sector on flash part");
    AST_FWB: assert property (flash_write_block == (readout_block || program_memory_write_protected))
        else $error("flash write block wrong");
    AST_RSV: assert property (clock_source_reserved == (clock_source_type == src_reserved))
        else $error("reserved source flag wrong");
    AST_MISUSE: assert property (pll_misuse == (pll_x2_enable && (clock_source_type == src_internal_rc
        || oscillator_freq_range != medium_power_range)))
        else $error("doubler misuse flag wrong");
    AST_STATIC: assert property (!$past(sys_rst) |-> $stable({watchdog_hw_always_on, voltage_detect_threshold,
        sector_zero_size, readout_block, clock_source_type, oscillator_freq_range, pll_x2_enable}))
        else $error("configuration moved outside reset");
    AST_RDATA: assert property (bus_rdata != 8'h00 |-> $past(bus_req.rd))
        else $error("read data without read");
    AST_WIPE_END: assert property (s_wipe_done |-> s_req_drop)
        else $error("wipe request held after done");
    AST_WIPE_HOLD: assert property (mem_erase_req && !mem_erase_done |=> mem_erase_req)
        else $error("wipe request dropped early");
    AST_ROM_FIXED: assert property (ROM_PART |-> !mem_erase_req)
        else $error("rom part started a wipe");
endmodule

bind option_byte_config_decoder option_chk #(.ROM_PART(ROM_PART)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .halt_entry(halt_entry), .sw_watchdog_enable(sw_watchdog_enable), .mem_erase_done(mem_erase_done),
    .mem_erase_req(mem_erase_req), .halt_reset_req(halt_reset_req), .watchdog_hw_always_on(watchdog_hw_always_on),
    .low_voltage_detector_on(low_voltage_detector_on),
    .auxiliary_voltage_detector_on(auxiliary_voltage_detector_on),
    .voltage_detect_threshold(voltage_detect_threshold), .sector_zero_size(sector_zero_size),
    .readout_block(readout_block), .flash_write_block(flash_write_block),
    .program_memory_write_protected(program_memory_write_protected), .clock_source_type(clock_source_type),
    .clock_source_reserved(clock_source_reserved), .oscillator_freq_range(oscillator_freq_range),
    .pll_x2_enable(pll_x2_enable), .pll_misuse(pll_misuse));

// file: bench/test_option_byte_config_decoder.sv
// self-checking bench: flash decoder and a fixed-option rom decoder
// assumes ship defaults FC/EF and the programmer model drives the bus
`timescale 1ns/1ps
`include "option_cfg.svh"
module test_option_byte_config_decoder
    import option_pkg::*;
;
    logic core_clk, sys_rst, factory_load, halt_entry, sw_watchdog_enable;
    logic prog_mode_pin, mem_erase_done, mem_erase_req, halt_reset_req;
    logic wdg_hw, lvd_on, aux_on, ro_blk, fw_blk, wp, irq_map, src_res, pll_en, pll_mis, rom_res;
    bus_req_t                  bus_req;
    logic [7:0]                bus_rdata, seen;
    voltage_detect_threshold_t vd;
    logic [1:0]                sec, rom_sec;
    clock_source_type_t        src, rom_src;
    oscillator_freq_range_t    rng;
    logic [18:0]               obs;
    logic [15:0]               rows [5] = '{16'hFCEF, 16'hE8E1, 16'hD442, 16'h40C5, 16'h82E7};
    int                        failures = 0, check_count = 0, cycles = 0;

    assign obs = {wdg_hw, lvd_on, aux_on, vd, sec, ro_blk, fw_blk, wp, irq_map, src, src_res, rng, pll_en, pll_mis};

    option_programmer u_prog (.core_clk(core_clk), .mem_erase_req(mem_erase_req), .bus_rdata(bus_rdata),
        .bus_req(bus_req), .prog_mode_pin(prog_mode_pin), .mem_erase_done(mem_erase_done));

    option_byte_config_decoder u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .factory_load(factory_load),
        .prog_mode_pin(prog_mode_pin), .bus_req(bus_req), .bus_rdata(bus_rdata), .halt_entry(halt_entry),
        .sw_watchdog_enable(sw_watchdog_enable), .mem_erase_done(mem_erase_done), .mem_erase_req(mem_erase_req),
        .halt_reset_req(halt_reset_req), .watchdog_hw_always_on(wdg_hw), .low_voltage_detector_on(lvd_on),
        .auxiliary_voltage_detector_on(aux_on), .voltage_detect_threshold(vd), .sector_zero_size(sec),
        .readout_block(ro_blk), .flash_write_block(fw_blk), .program_memory_write_protected(wp),
        .port_c_irq_mapping(irq_map), .clock_source_type(src), .clock_source_reserved(src_res),
        .oscillator_freq_range(rng), .pll_x2_enable(pll_en), .pll_misuse(pll_mis));

    option_byte_config_decoder #(.ROM_PART(1'h1), .ROM_OPT0(8'h0E), .ROM_OPT1(8'h57)) u_rom (
        .core_clk(core_clk), .sys_rst(sys_rst), .factory_load(factory_load), .prog_mode_pin(prog_mode_pin),
        .bus_req(bus_req), .bus_rdata(), .halt_entry(halt_entry), .sw_watchdog_enable(sw_watchdog_enable),
        .mem_erase_done(mem_erase_done), .mem_erase_req(), .halt_reset_req(), .watchdog_hw_always_on(),
        .low_voltage_detector_on(), .auxiliary_voltage_detector_on(), .voltage_detect_threshold(),
        .sector_zero_size(rom_sec), .readout_block(), .flash_write_block(), .program_memory_write_protected(),
        .port_c_irq_mapping(), .clock_source_type(rom_src), .clock_source_reserved(rom_res),
        .oscillator_freq_range(), .pll_x2_enable(), .pll_misuse());

    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [18:0] decode(input logic [7:0] a, input logic [7:0] b);
        logic [2:0] r;
        r = b[3] ? 3'h0 : {1'h0, b[2:1]} + 3'h1;
        decode = {~a[6], a[5:4] != 2'h3, a[5:4] != 2'h3, ~a[5:4], (a[3:2] == 2'h3) ? 2'h2 : a[3:2],
                  a[1], a[1] | a[0], a[0], b[7], b[5:4], b[5:4] == 2'h1, r, ~b[0],
                  ~b[0] & (b[5:4] == 2'h2 || b[3:1] != 3'h1)};
    endfunction

    task automatic chk(input string what, input logic [18:0] got, input logic [18:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic restart();
        @(posedge core_clk);
        sys_rst <= 1'h1;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'h0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic close_out();
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        sys_rst = 1'h1;
        factory_load = 1'h1;
        halt_entry = 1'h0;
        sw_watchdog_enable = 1'h0;
        @(posedge core_clk);
        factory_load <= 1'h0;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'h0;
        @(negedge core_clk);
        chk("reset_rdata", 19'({mem_erase_req, halt_reset_req, bus_rdata}), 19'h0);
        chk("ship_cfg", obs, decode(`SHIP_OPT0, `SHIP_OPT1));
        u_prog.set_mode(1'h1);
        repeat (4) @(posedge core_clk);
        foreach (rows[i]) begin
            @(posedge core_clk);
            factory_load <= 1'h1;
            sw_watchdog_enable <= i[0];
            @(posedge core_clk);
            factory_load <= 1'h0;
            u_prog.wr(`REG_OPT_BYTE0, rows[i][15:8]);
            u_prog.wr(`REG_OPT_BYTE1, rows[i][7:0]);
            u_prog.wr(`REG_COMMAND, 8'h01);
            u_prog.rd(`REG_OPT_BYTE0, seen);
            chk("opt0", 19'(seen), 19'(rows[i][15:8]));
            restart();
            chk("cfg", obs, decode(rows[i][15:8], rows[i][7:0]));
            @(posedge core_clk);
            halt_entry <= 1'h1;
            @(posedge core_clk);
            halt_entry <= 1'h0;
            @(negedge core_clk);
            chk("halt", 19'(halt_reset_req), 19'(rows[i][15] & (~rows[i][14] | i[0])));
        end
        u_prog.rd(4'h2, seen);
        chk("unmapped", 19'(seen), 19'h0);
        u_prog.wr(`REG_COMMAND, 8'h02);
        u_prog.rd(`REG_STATUS, seen);
        chk("wipe_busy", 19'(seen), 19'h05);
        for (int k = 0; k < 50 && mem_erase_req; k++) @(negedge core_clk);
        repeat (2) @(posedge core_clk);
        u_prog.rd(`REG_OPT_BYTE0, seen);
        chk("erased0", 19'(seen), 19'hFF);
        u_prog.rd(`REG_OPT_BYTE1, seen);
        chk("erased1", 19'(seen), 19'hFF);
        u_prog.wr(`REG_OPT_BYTE0, 8'h00);
        u_prog.wr(`REG_COMMAND, 8'h01);
        u_prog.rd(`REG_OPT_BYTE0, seen);
        chk("locked", 19'(seen), 19'hFF);
        u_prog.rd(`REG_STATUS, seen);
        chk("refused", 19'(seen), 19'h16);
        restart();
        chk("protected_cfg", obs, decode(8'hFF, 8'hFF));
        chk("rom_cfg", 19'({rom_src, rom_res, rom_sec}), 19'h0F);
        u_prog.set_mode(1'h0);
        repeat (6) @(posedge core_clk);
        u_prog.rd(`REG_OPT_BYTE0, seen);
        chk("hidden", 19'(seen), 19'h0);
        close_out();
    end
endmodule
